// ==== src/bhlp_top.v ====
// Host-link wake, handshake and power-mode control
`timescale 1ns/1ns
`include "bhlp_defines.vh"
module bhlp_top (
   input wire clk,
   input wire sys_rst,
   input wire if_sel_uart,
   input wire cfg_we,
   input wire [15:0] cfg_version,
   input wire [15:0] cfg_scan_ms,
   input wire boot_notify_flag,
   input wire cfg_uart_stop,
   input wire cfg_irq_before_tx,
   input wire [15:0] cfg_tx_delay_ms,
   input wire [15:0] cfg_idle_ms,
   input wire [7:0] cfg_fail_max,
   input wire [15:0] cfg_lock_s,
   input wire host_cs_n,
   input wire host_rx,
   input wire boot_done,
   input wire hdr_valid,
   input wire [15:0] hdr_version,
   input wire finger_wait,
   input wire nav_gesture,
   input wire img_process,
   input wire list_templates,
   input wire id_fail,
   input wire id_match,
   input wire id_request,
   input wire [7:0] tx_data,
   input wire tx_valid,
   output wire tx_ready,
   output reg [7:0] link_data,
   output reg link_valid,
   input wire link_ready,
   output reg host_irq,
   output reg [1:0] power_mode,
   output reg scan_strobe,
   output reg boot_event,
   output reg frame_accept,
   output reg frame_drop,
   output reg id_grant,
   output reg id_locked,
   output reg cfg_rejected
);
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam [17:0] MS_CYC = `BHLP_MS_CYCLES;
   localparam [1:0] TX_IDLE = `BHLP_TX_IDLE;
   localparam [1:0] TX_WAIT = `BHLP_TX_WAIT;
   localparam [1:0] TX_SEND = `BHLP_TX_SEND;

   function [15:0] inc_sat;
      input [15:0] v;
      begin
         inc_sat = (v == 16'hFFFF) ? v : v + 16'h0001;
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg cs_m_q;
   reg cs_s_q;
   reg cs_p_q;
   reg rx_m_q;
   reg rx_s_q;
   reg rx_p_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         cs_p_q <= 1'b1;
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
         rx_p_q <= 1'b1;
      end else begin
         cs_m_q <= host_cs_n;
         cs_s_q <= cs_m_q;
         cs_p_q <= cs_s_q;
         rx_m_q <= host_rx;
         rx_s_q <= rx_m_q;
         rx_p_q <= rx_s_q;
      end
   end
   // Wake on any select edge or receive break start
   wire wake_evt = (cs_s_q != cs_p_q) || (rx_p_q && !rx_s_q);

   // ----------------------------------------
   // Millisecond tick
   // ----------------------------------------
   reg [17:0] ms_cnt_q;
   reg ms_tick_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         ms_cnt_q <= 18'h00000;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == MS_CYC - 18'h00001) begin
         ms_cnt_q <= 18'h00000;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q <= ms_cnt_q + 18'h00001;
         ms_tick_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   reg [15:0] scan_ms_q;
   reg boot_flag_q;
   reg uart_stop_q;
   reg irq_tx_q;
   reg [15:0] tx_dly_q;
   reg [15:0] idle_ms_q;
   reg [7:0] fail_max_q;
   reg [15:0] lock_s_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         scan_ms_q <= `BHLP_SCAN_MS_DEF;
         boot_flag_q <= 1'b1;
         uart_stop_q <= 1'b0;
         irq_tx_q <= 1'b1;
         tx_dly_q <= `BHLP_TXDLY_MS_DEF;
         idle_ms_q <= `BHLP_IDLE_MS_DEF;
         fail_max_q <= `BHLP_FAIL_MAX_DEF;
         lock_s_q <= `BHLP_LOCK_S_DEF;
         cfg_rejected <= 1'b0;
      end else if (cfg_we) begin
         cfg_rejected <= (cfg_version != `BHLP_CFG_VER);
         if (cfg_version == `BHLP_CFG_VER) begin
            scan_ms_q <= cfg_scan_ms;
            boot_flag_q <= boot_notify_flag;
            uart_stop_q <= cfg_uart_stop;
            irq_tx_q <= cfg_irq_before_tx;
            tx_dly_q <= cfg_tx_delay_ms;
            idle_ms_q <= cfg_idle_ms;
            fail_max_q <= cfg_fail_max;
            lock_s_q <= cfg_lock_s;
         end
      end
   end

   // ----------------------------------------
   // Frame version filter and boot event
   // ----------------------------------------
   reg boot_seen_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         frame_accept <= 1'b0;
         frame_drop <= 1'b0;
         boot_event <= 1'b0;
         boot_seen_q <= 1'b0;
      end else begin
         frame_accept <= hdr_valid && (hdr_version == `BHLP_PROTO_VER);
         frame_drop <= hdr_valid && (hdr_version != `BHLP_PROTO_VER);
         boot_event <= boot_done && !boot_seen_q && boot_flag_q;
         if (boot_done) begin
            boot_seen_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Identify lockout
   // ----------------------------------------
   reg [7:0] fail_cnt_q;
   reg [15:0] lock_ms_q;
   // Kept to 16 bits: lockouts above 65 s wrap
   wire [31:0] lock_ms_prod = lock_s_q * `BHLP_MS_PER_S;
   wire [15:0] lock_ms_full = lock_ms_prod[15:0];
   always @(posedge clk) begin
      if (sys_rst) begin
         fail_cnt_q <= 8'h00;
         lock_ms_q <= 16'h0000;
         id_locked <= 1'b0;
         id_grant <= 1'b0;
      end else begin
         id_grant <= id_request && !id_locked;
         if (id_locked) begin
            if (ms_tick_q) begin
               lock_ms_q <= lock_ms_q - 16'h0001;
               if (lock_ms_q <= 16'h0001) begin
                  id_locked <= 1'b0;
               end
            end
         end else if (id_match) begin
            fail_cnt_q <= 8'h00;
         end else if (id_fail) begin
            if (fail_cnt_q >= fail_max_q) begin
               fail_cnt_q <= 8'h00;
               lock_ms_q <= lock_ms_full;
               id_locked <= (lock_ms_full != 16'h0000);
            end else begin
               fail_cnt_q <= fail_cnt_q + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Outbound FIFO
   // ----------------------------------------
   wire [7:0] fq_data;
   wire fq_valid;
   reg fq_pop;
   bhlp_fifo #(
      .WIDTH(`BHLP_WORD_W),
      .DEPTH(`BHLP_FIFO_DEPTH),
      .AW(`BHLP_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(fq_data),
      .out_valid(fq_valid),
      .out_ready(fq_pop)
   );

   // ----------------------------------------
   // Transmit sequencer
   // ----------------------------------------
   reg [1:0] tx_st_q;
   reg [15:0] tx_ms_q;
   always @* begin
      fq_pop = 1'b0;
      if (tx_st_q == TX_SEND && fq_valid && (!link_valid || link_ready)) begin
         fq_pop = 1'b1;
      end
   end
   always @(posedge clk) begin
      if (sys_rst) begin
         tx_st_q <= TX_IDLE;
         tx_ms_q <= 16'h0000;
         host_irq <= 1'b0;
         link_valid <= 1'b0;
         link_data <= 8'h00;
      end else begin
         if (link_valid && link_ready) begin
            link_valid <= 1'b0;
         end
         if (fq_pop) begin
            link_data <= fq_data;
            link_valid <= 1'b1;
         end
         case (tx_st_q)
            TX_IDLE: begin
               if (fq_valid) begin
                  host_irq <= irq_tx_q || !if_sel_uart;
                  tx_ms_q <= 16'h0000;
                  tx_st_q <= (if_sel_uart && irq_tx_q) ? TX_WAIT : TX_SEND;
               end
            end
            TX_WAIT: begin
               // whole ms; first tick may be partial
               if (tx_dly_q == 16'h0000 || tx_ms_q > tx_dly_q) begin
                  tx_st_q <= TX_SEND;
               end else if (ms_tick_q) begin
                  tx_ms_q <= inc_sat(tx_ms_q);
               end
            end
            TX_SEND: begin
               if (!fq_valid && !link_valid) begin
                  host_irq <= 1'b0;
                  tx_st_q <= TX_IDLE;
               end
            end
            default: begin
               tx_st_q <= TX_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Power mode
   // ----------------------------------------
   // Any link or data activity counts as busy
   wire busy = wake_evt || hdr_valid || cfg_we || nav_gesture || fq_valid || link_valid
      || tx_st_q != TX_IDLE || !cs_s_q;
   // UART without stop mode must stay awake to hear data
   wire may_sleep = !if_sel_uart || uart_stop_q;
   reg [15:0] idle_cnt_q;
   reg [15:0] scan_cnt_q;
   always @(posedge clk) begin
      if (sys_rst) begin
         power_mode <= `BHLP_PM_ACTIVE;
         idle_cnt_q <= 16'h0000;
         scan_cnt_q <= 16'h0000;
         scan_strobe <= 1'b0;
      end else begin
         scan_strobe <= 1'b0;
         if (busy) begin
            idle_cnt_q <= 16'h0000;
         end else if (ms_tick_q) begin
            idle_cnt_q <= inc_sat(idle_cnt_q);
         end
         if (img_process || list_templates) begin
            power_mode <= `BHLP_PM_HIPERF;
         end else if (busy) begin
            power_mode <= `BHLP_PM_ACTIVE;
         end else if (finger_wait) begin
            power_mode <= `BHLP_PM_DETECT;
         end else if (may_sleep && (idle_ms_q == 16'h0000 || idle_cnt_q > idle_ms_q)) begin
            power_mode <= `BHLP_PM_SLEEP;
         end else begin
            power_mode <= `BHLP_PM_ACTIVE;
         end
         if (power_mode == `BHLP_PM_DETECT) begin
            if (ms_tick_q) begin
               if (scan_cnt_q >= scan_ms_q) begin
                  scan_cnt_q <= 16'h0000;
                  scan_strobe <= 1'b1;
               end else begin
                  scan_cnt_q <= scan_cnt_q + 16'h0001;
               end
            end
         end else begin
            scan_cnt_q <= 16'h0000;
         end
      end
   end
endmodule

// ==== src/bhlp_defines.vh ====
// Constants for the host-link wake and power-mode block
`ifndef BHLP_DEFINES_VH
`define BHLP_DEFINES_VH

// ----------------------------------------
// Clock and times
// ----------------------------------------
`define BHLP_CLK_MHZ 250
`define BHLP_SCAN_MS_DEF 16'h0022
`define BHLP_TXDLY_MS_DEF 16'h0001
`define BHLP_IDLE_MS_DEF 16'h0000
`define BHLP_LOCK_S_DEF 16'h000F
`define BHLP_FAIL_MAX_DEF 8'h05
`define BHLP_CFG_VER 16'h0001
`define BHLP_PROTO_VER 16'h0004
// One ms of clk cycles at 250 MHz
`define BHLP_MS_CYCLES 18'h3D090
`define BHLP_MS_PER_S 16'h03E8

// ----------------------------------------
// Power modes
// ----------------------------------------
`define BHLP_PM_SLEEP 2'h0
`define BHLP_PM_DETECT 2'h1
`define BHLP_PM_ACTIVE 2'h2
`define BHLP_PM_HIPERF 2'h3

// ----------------------------------------
// Transmit sequencer states
// ----------------------------------------
`define BHLP_TX_IDLE 2'h0
`define BHLP_TX_WAIT 2'h1
`define BHLP_TX_SEND 2'h2

// ----------------------------------------
// Interface select and FIFO
// ----------------------------------------
`define BHLP_IF_SPI 2'h0
`define BHLP_IF_UART 2'h1
`define BHLP_FIFO_DEPTH 32
`define BHLP_FIFO_AW 5
`define BHLP_WORD_W 8

`endif

// ==== src/bhlp_fifo.v ====
// Synchronous FIFO for outbound host data
`timescale 1ns/1ns
module bhlp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   reg ready_q;
   wire [AW:0] wr_d;
   wire [AW:0] rd_d;
   wire full;
   wire full_d;
   wire empty;
   wire push;
   wire pop;

   // Ready registered so the top sees it straight from a flop
   assign full = !ready_q;
   assign wr_d = push ? wr_q + 1'b1 : wr_q;
   assign rd_d = pop ? rd_q + 1'b1 : rd_q;
   assign full_d = (wr_d[AW] != rd_d[AW]) && (wr_d[AW-1:0] == rd_d[AW-1:0]);
   assign empty = (wr_q == rd_q);
   assign in_ready = ready_q;
   assign out_valid = !empty;
   assign out_data = mem[rd_q[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
         ready_q <= 1'b1;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         ready_q <= !full_d;
      end
   end
endmodule

// ==== tb/bhlp_properties.sv ====
// Port-level assertions for the host-link power block
`timescale 1ns/1ns
`include "bhlp_defines.vh"
module bhlp_properties (
   input wire clk,
   input wire sys_rst,
   input wire if_sel_uart,
   input wire cfg_we,
   input wire [15:0] cfg_version,
   input wire cfg_irq_before_tx,
   input wire [7:0] cfg_fail_max,
   input wire host_cs_n,
   input wire hdr_valid,
   input wire [15:0] hdr_version,
   input wire finger_wait,
   input wire img_process,
   input wire list_templates,
   input wire id_fail,
   input wire id_match,
   input wire id_request,
   input wire link_valid,
   input wire host_irq,
   input wire [1:0] power_mode,
   input wire frame_accept,
   input wire frame_drop,
   input wire id_grant,
   input wire id_locked,
   input wire cfg_rejected
);
   // Fail run as the block should count it; assumes cfg ports change only with a load
   reg [7:0] fails_q;
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   always @(posedge clk) begin
      if (sys_rst || id_match || id_locked)
         fails_q <= 8'h00;
      else if (id_fail)
         fails_q <= fails_q + 8'h01;
   end
   a_cfg_refuse: assert property (
      cfg_we |=> cfg_rejected == ($past(cfg_version) != `BHLP_CFG_VER))
      else $error("config refusal wrong");
   a_frame_accept: assert property (
      hdr_valid && hdr_version == `BHLP_PROTO_VER |=> frame_accept && !frame_drop)
      else $error("good frame not accepted");
   a_frame_drop: assert property (
      hdr_valid && hdr_version != `BHLP_PROTO_VER |=> frame_drop && !frame_accept)
      else $error("bad frame not dropped");
   a_lock_onset: assert property (
      id_fail && !id_locked |=> id_locked == ($past(fails_q) == $past(cfg_fail_max)))
      else $error("lockout onset wrong");
   a_lock_blocks: assert property (
      id_request && id_locked |=> !id_grant)
      else $error("grant while locked");
   a_grant_free: assert property (
      id_request && !id_locked |=> id_grant)
      else $error("no grant while unlocked");
   a_hiperf_cause: assert property (
      power_mode == `BHLP_PM_HIPERF |-> $past(img_process || list_templates))
      else $error("high performance without cause");
   a_detect_cause: assert property (
      power_mode == `BHLP_PM_DETECT |-> $past(finger_wait))
      else $error("detect mode without finger wait");
   a_select_wakes: assert property (
      !host_cs_n [*5] |-> power_mode[1])
      else $error("asleep while selected");
   a_irq_first: assert property (
      $rose(link_valid) && (cfg_irq_before_tx || !if_sel_uart) |-> $past(host_irq))
      else $error("transmit before interrupt");
endmodule
bind bhlp_top bhlp_properties u_bhlp_properties (.*);

// ==== tb/bhlp_host_model.sv ====
// Host microcontroller model at the link side
`timescale 1ns/1ns
module bhlp_host_model (
   input wire clk,
   input wire [7:0] link_data,
   input wire link_valid,
   output reg link_ready,
   output reg host_cs_n,
   output reg host_rx,
   input wire stall
);
   logic [7:0] rx_q[$];
   initial begin
      link_ready = 1'b0;
      host_cs_n = 1'b1;
      host_rx = 1'b1;
   end
   // Slow host holds ready low
   always @(negedge clk) link_ready <= !stall;
   always @(posedge clk) if (link_valid && link_ready) rx_q.push_back(link_data);
   // Select held low, whole, as a wake
   task wake_cs(input int n);
      host_cs_n = 1'b0;
      repeat (n) @(negedge clk);
      host_cs_n = 1'b1;
   endtask
   // Break of 12 bit times at 125 ns
   task send_break();
      host_rx = 1'b0;
      #1500;
      host_rx = 1'b1;
   endtask
endmodule

// ==== tb/tb_bhlp_top.sv ====
// Self-checking bench for the host-link power block
`timescale 1ns/1ns
`include "bhlp_defines.vh"
module tb_bhlp_top;
   logic clk, sys_rst, if_sel_uart, cfg_we, boot_notify_flag, cfg_uart_stop, cfg_irq_before_tx;
   logic [15:0] cfg_version, cfg_scan_ms, cfg_tx_delay_ms, cfg_idle_ms, cfg_lock_s, hdr_version;
   logic [7:0] cfg_fail_max, tx_data;
   logic boot_done, hdr_valid, finger_wait, nav_gesture, img_process, list_templates;
   logic id_fail, id_match, id_request, tx_valid, stall;
   wire host_cs_n, host_rx, tx_ready, link_valid, link_ready, host_irq, scan_strobe, boot_event;
   wire frame_accept, frame_drop, id_grant, id_locked, cfg_rejected;
   wire [7:0] link_data;
   wire [1:0] power_mode;
   int fail_count, checks;
   bhlp_top u_bhlp_top (.*);
   bhlp_host_model u_bhlp_host_model (.*);
   always #2 clk = ~clk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h got %h", n, e, g);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task do_reset();
      sys_rst = 1'b1;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
   endtask
   task wait_mode(input logic [1:0] m);
      for (int i = 0; i < 100 && power_mode !== m; i++)
         @(negedge clk);
      chk("power_mode", m, power_mode);
   endtask
   task complete_run();
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_boot(input logic flag);
      logic [15:0] seen;
      seen = 16'h0000;
      do_reset();
      boot_notify_flag = flag;
      pulse(cfg_we);
      boot_done = 1'b1;
      repeat (20) begin
         @(negedge clk);
         seen = seen + boot_event;
      end
      boot_done = 1'b0;
      chk("boot_event", {15'h0000, flag}, seen); // one event only when flag set
   endtask
   task t_cfg();
      cfg_version = 16'h0002;
      pulse(cfg_we);
      chk("cfg_rejected", 16'h0001, cfg_rejected); // bad version refused
      cfg_version = `BHLP_CFG_VER;
      pulse(cfg_we);
      chk("cfg_rejected", 16'h0000, cfg_rejected); // version one taken
   endtask
   task t_frame(input logic [15:0] v);
      hdr_version = v;
      pulse(hdr_valid);
      chk("frame_accept", v == `BHLP_PROTO_VER, frame_accept); // matching version kept
      chk("frame_drop", v != `BHLP_PROTO_VER, frame_drop); // others discarded
   endtask
   task t_lock();
      do_reset();
      repeat (5) pulse(id_fail);
      pulse(id_match);
      repeat (5) pulse(id_fail);
      chk("id_locked", 16'h0000, id_locked); // match restarts the run
      pulse(id_fail);
      chk("id_locked", 16'h0001, id_locked); // sixth fail locks
      pulse(id_request);
      chk("id_grant", 16'h0000, id_grant); // blocked while locked
      do_reset();
      pulse(id_request);
      chk("id_grant", 16'h0001, id_grant); // reset clears lockout
   endtask
   task t_fifo();
      logic [15:0] n;
      n = 16'h0000;
      stall = 1'b1;
      u_bhlp_host_model.rx_q.delete();
      @(negedge clk);
      for (int i = 0; i < 40; i++) begin
         tx_data = n[7:0];
         tx_valid = 1'b1;
         if (tx_ready === 1'b1)
            n++;
         @(negedge clk);
      end
      tx_valid = 1'b0;
      chk("tx_ready", 16'h0000, tx_ready);
      chk("fifo_fill", 16'h0001, {15'h0000, n >= 16'h0020});
      chk("host_irq", 16'h0001, host_irq); // raised while data waits
      stall = 1'b0;
      u_bhlp_host_model.wake_cs(8); // header read
      @(negedge clk);
      u_bhlp_host_model.wake_cs(8); // remainder after reselect
      for (int i = 0; i < 300 && u_bhlp_host_model.rx_q.size() < n; i++)
         @(negedge clk);
      repeat (4) @(negedge clk);
      chk("bytes_out", n, 16'(u_bhlp_host_model.rx_q.size()));
      for (int i = 0; i < n; i++)
         chk("link_data", 16'(i[7:0]), {8'h00, u_bhlp_host_model.rx_q[i]});
      chk("host_irq", 16'h0000, host_irq); // dropped once drained
   endtask
   task t_uart(input logic flag);
      logic seen;
      int i;
      seen = 1'b0;
      if_sel_uart = 1'b1;
      cfg_irq_before_tx = flag;
      // Zero delay; the default 1 ms is too long to simulate
      cfg_tx_delay_ms = 16'h0000;
      pulse(cfg_we);
      tx_data = 8'hA5;
      pulse(tx_valid);
      for (i = 0; i < 50 && link_valid !== 1'b1; i++) begin
         seen = seen | host_irq;
         @(negedge clk);
      end
      chk("host_irq", flag, seen); // raised only when enabled
      chk("link_valid", 16'h0001, link_valid); // zero delay starts promptly
      chk("link_data", 16'h00A5, link_data);
   endtask
   task t_power();
      if_sel_uart = 1'b0;
      do_reset();
      wait_mode(`BHLP_PM_SLEEP); // SPI idle sleeps
      finger_wait = 1'b1;
      wait_mode(`BHLP_PM_DETECT); // waiting on the finger
      repeat (20) begin
         @(negedge clk);
         chk("scan_strobe", 16'h0000, scan_strobe); // no check before interval
      end
      nav_gesture = 1'b1;
      wait_mode(`BHLP_PM_ACTIVE); // gesture work wakes
      list_templates = 1'b1;
      wait_mode(`BHLP_PM_HIPERF); // listing runs fast
      {finger_wait, nav_gesture, list_templates} = 3'h0;
      wait_mode(`BHLP_PM_SLEEP);
      img_process = 1'b1;
      wait_mode(`BHLP_PM_HIPERF); // image work runs fast
      img_process = 1'b0;
      wait_mode(`BHLP_PM_SLEEP);
      fork
         u_bhlp_host_model.wake_cs(20);
         wait_mode(`BHLP_PM_ACTIVE); // host select wakes
      join
      if_sel_uart = 1'b1;
      cfg_uart_stop = 1'b1;
      pulse(cfg_we);
      wait_mode(`BHLP_PM_SLEEP); // stop mode lets UART sleep
      fork
         u_bhlp_host_model.send_break();
         wait_mode(`BHLP_PM_ACTIVE); // break wakes
      join
   endtask
   initial begin
      clk = 1'b0;
      {if_sel_uart, cfg_we, cfg_uart_stop, boot_done, hdr_valid, finger_wait, nav_gesture} = 7'h00;
      {img_process, list_templates, id_fail, id_match, id_request, tx_valid, stall} = 7'h00;
      {boot_notify_flag, cfg_irq_before_tx} = 2'h3;
      cfg_version = `BHLP_CFG_VER;
      cfg_scan_ms = `BHLP_SCAN_MS_DEF;
      cfg_tx_delay_ms = `BHLP_TXDLY_MS_DEF;
      cfg_idle_ms = `BHLP_IDLE_MS_DEF;
      cfg_lock_s = `BHLP_LOCK_S_DEF;
      cfg_fail_max = `BHLP_FAIL_MAX_DEF;
      hdr_version = 16'h0000;
      tx_data = 8'h00;
      do_reset();
      t_boot(1'b0);
      t_boot(1'b1);
      t_cfg();
      t_frame(`BHLP_PROTO_VER);
      t_frame(16'h0001);
      t_frame(16'hFFFF);
      t_lock();
      t_fifo();
      t_uart(1'b1);
      t_uart(1'b0);
      t_power();
      complete_run();
   end
   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
endmodule
